// ### pkg/acr_pkg.sv
// Purpose: Constants for the converter serial readout block.
// Assumes: ref_clk at 20 MHz; link pins sampled through two flip-flops.
// Notes:   Result word and status bits are shifted most significant bit first.
package acr_pkg;
  localparam int unsigned RES_W        = 16;
  localparam int unsigned STAT_W       = 6;
  localparam int unsigned SHIFT_W      = RES_W + STAT_W;
  localparam int unsigned BUSY_EDGE    = 17;
  localparam int unsigned CLK_MHZ      = 20;
  localparam int unsigned CONV_NS      = 300;
  localparam int unsigned CONV_CYC     = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CMD_W        = 8;
  localparam int unsigned CFG_W        = 8;
  localparam int unsigned CFG_FAST_BIT = 1;
  localparam int unsigned CFG_STAT_BIT = 4;
  localparam logic [7:0]  CMD_WRITE    = 8'h14;
  localparam logic [7:0]  CFG_RESET    = 8'he1;
  typedef enum logic [2:0] {
    ACR_IDLE  = 3'b000,
    ACR_CONV  = 3'b001,
    ACR_READ  = 3'b010,
    ACR_WRITE = 3'b011
  } acr_state_t;
endpackage

// ### pkg/acr_edge_if.sv
`timescale 1ns/1ns
// Purpose: Carries synchronised link levels and their edge pulses.
// Assumes: Driven by the synchroniser, read by the main block.
// Notes:   All signals are on ref_clk.
interface acr_edge_if;
  logic trig;
  logic sin;
  logic sclk;
  logic trig_rise;
  logic sin_rise;
  logic sclk_rise;
  logic sclk_fall;
  modport src (output trig, sin, sclk, trig_rise, sin_rise, sclk_rise, sclk_fall);
  modport dst (input  trig, sin, sclk, trig_rise, sin_rise, sclk_rise, sclk_fall);
endinterface

// ### design/acr_sync.sv
`timescale 1ns/1ns
// Purpose: Two-stage synchronisers and edge detection for the link pins.
// Assumes: Pins are asynchronous to ref_clk.
// Notes:   Edge detectors read only the second stage and later.
module acr_sync (
  input  wire logic   ref_clk,
  input  wire logic   rst,
  input  wire logic   conversion_trigger,
  input  wire logic   serial_in_line,
  input  wire logic   serial_clk,
  acr_edge_if.src     edges
);
  logic [2:0] meta;
  logic [2:0] stable;
  logic [2:0] last;
  logic [2:0] pins;

  // Gather the pins into one vector.
  assign pins = {serial_clk, serial_in_line, conversion_trigger};

  // Two flip-flops per pin, then one more stage for edge finding.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta   <= 3'h0;
      stable <= 3'h0;
      last   <= 3'h0;
    end else begin
      meta   <= pins;
      stable <= meta;
      last   <= stable;
    end
  end

  // Levels and one-cycle edge pulses.
  assign edges.trig      = stable[0];
  assign edges.sin       = stable[1];
  assign edges.sclk      = stable[2];
  assign edges.trig_rise = stable[0] & ~last[0];
  assign edges.sin_rise  = stable[1] & ~last[1];
  assign edges.sclk_rise = stable[2] & ~last[2];
  assign edges.sclk_fall = ~stable[2] & last[2];
endmodule

// ### design/acr_conv.sv
`timescale 1ns/1ns
// Purpose: Conversion timer standing in for the converter core.
// Assumes: start is a one-cycle pulse.
// Notes:   The result is a free-running sample count taken at the end.
module acr_conv (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      start,
  output logic                           busy,
  output logic                           done,
  output logic [acr_pkg::RES_W-1:0]      result
);
  logic [7:0]                  count;
  logic [acr_pkg::RES_W-1:0]   sample;

  // Count down the conversion time; the count holds when idle while the sample count runs on.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count  <= 8'h00;
      busy   <= 1'b0;
      done   <= 1'b0;
      sample <= 16'h0000;
      result <= 16'h0000;
    end else begin
      sample <= sample + 16'h0001;
      done   <= 1'b0;
      if (start) begin
        busy  <= 1'b1;
        count <= 8'(acr_pkg::CONV_CYC - 1);
      end else if (busy && count == 8'h00) begin
        busy   <= 1'b0;
        done   <= 1'b1;
        result <= sample;
      end else if (busy) begin
        count <= count - 8'h01;
      end
    end
  end
endmodule

// ### design/acr_top.sv
`timescale 1ns/1ns
// Purpose: Serial readout of a converter in busy-indicator and daisy-chain modes.
// Assumes: Host obeys its own timing; serial clock quiet during conversion.
// Notes:   Output enable is low while the output line is driven.
module acr_top (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic conversion_trigger,
  input  wire logic serial_in_line,
  input  wire logic serial_clk,
  output logic      serial_out_line,
  output logic      serial_out_oe_n,
  output logic      chain_mode,
  output logic      acquiring
);
  acr_edge_if edges ();
  acr_pkg::acr_state_t state;
  acr_pkg::acr_state_t next_state;

  logic                             conv_busy;
  logic                             conv_done;
  logic [acr_pkg::RES_W-1:0]        conv_result;
  logic [acr_pkg::SHIFT_W-1:0]      shreg;
  logic [4:0]                       fall_cnt;
  logic [acr_pkg::CMD_W+acr_pkg::CFG_W-1:0] wr_sreg;
  logic [4:0]                       wr_cnt;
  logic [acr_pkg::CFG_W-1:0]        cfg;
  logic                             mode_chain;
  logic                             start;
  logic                             status_en;
  logic                             fast_en;
  logic                             rd_drive;
  logic                             rd_end;
  logic                             low_force;
  logic                             next_oe_n;
  logic                             next_out;
  logic [4:0]                       read_len;
  logic [4:0]                       ins_idx;
  logic                             chain_in;
  logic [acr_pkg::SHIFT_W-1:0]      shifted;

  acr_sync u_sync (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .conversion_trigger (conversion_trigger),
    .serial_in_line     (serial_in_line),
    .serial_clk         (serial_clk),
    .edges              (edges)
  );

  acr_conv u_conv (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (start),
    .busy    (conv_busy),
    .done    (conv_done),
    .result  (conv_result)
  );

  assign start     = edges.trig_rise && (state != acr_pkg::ACR_CONV);
  assign status_en = cfg[acr_pkg::CFG_STAT_BIT];
  assign fast_en   = cfg[acr_pkg::CFG_FAST_BIT] & ~mode_chain;
  assign low_force = ~edges.sin & ~edges.trig;
  assign read_len  = status_en ? 5'(acr_pkg::SHIFT_W) : 5'(acr_pkg::RES_W);
  // Captured chain bits enter at the lowest bit of the word that is read out.
  assign ins_idx   = 5'(acr_pkg::SHIFT_W) - read_len;

  // next shift value with the chain input inserted.
  always_comb begin
    shifted = {shreg[acr_pkg::SHIFT_W-2:0], 1'b0};
    if (mode_chain) begin
      shifted[ins_idx] = chain_in;
    end
  end
  // release at 17th fall or input rise
  assign rd_end    = (!mode_chain && state == acr_pkg::ACR_READ) &&
                     (edges.sin_rise ||
                      (edges.sclk_fall && fall_cnt == 5'(acr_pkg::BUSY_EDGE - 1)));

  // Next state of the readout sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      acr_pkg::ACR_IDLE: begin
        if (start) begin
          next_state = acr_pkg::ACR_CONV;
        end else if (low_force && edges.sclk_rise) begin
          next_state = acr_pkg::ACR_WRITE;
        end
      end
      acr_pkg::ACR_CONV: begin
        if (conv_done) begin
          next_state = acr_pkg::ACR_READ;
        end
      end
      acr_pkg::ACR_READ: begin
        if (start) begin
          next_state = acr_pkg::ACR_CONV;
        end else if (rd_end || (mode_chain && !edges.trig)) begin
          next_state = acr_pkg::ACR_IDLE;
        end
      end
      acr_pkg::ACR_WRITE: begin
        if (edges.trig_rise) begin
          next_state = acr_pkg::ACR_CONV;
        end else if (edges.trig) begin
          next_state = acr_pkg::ACR_IDLE;
        end
      end
      default: next_state = acr_pkg::ACR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state     <= acr_pkg::ACR_IDLE;
      acquiring <= 1'b1;
    end else begin
      state     <= start ? acr_pkg::ACR_CONV : next_state;
      acquiring <= ~conv_busy & ~start;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_chain <= 1'b0;
      chain_mode <= 1'b0;
    end else begin
      if (start) begin
        mode_chain <= ~edges.sclk & ~edges.sin;
      end
      chain_mode <= start ? (~edges.sclk & ~edges.sin) : mode_chain;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shreg    <= '0;
      fall_cnt <= 5'h00;
      chain_in <= 1'b0;
    end else if (conv_done) begin
      // six status bits follow the result
      shreg    <= {conv_result, 2'b00, cfg[3:0]};
      fall_cnt <= 5'h00;
    end else if (state == acr_pkg::ACR_READ) begin
      if (edges.sclk_rise && mode_chain) begin
        chain_in <= edges.sin;
      end
      // The first busy-mode fall only ends the busy low; the MSB follows it.
      if (edges.sclk_fall) begin
        fall_cnt <= fall_cnt + 5'h01;
        if (mode_chain || fall_cnt != 5'h00) begin
          shreg <= shifted;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_sreg <= 16'h0000;
      wr_cnt  <= 5'h00;
      cfg     <= acr_pkg::CFG_RESET;
    end else if (state == acr_pkg::ACR_WRITE || (state == acr_pkg::ACR_IDLE && low_force)) begin
      if (edges.sclk_rise) begin
        wr_sreg <= {wr_sreg[14:0], edges.sin};
        wr_cnt  <= (wr_cnt == 5'h0f) ? 5'h00 : wr_cnt + 5'h01;
        if (wr_cnt == 5'h0f && wr_sreg[14:7] == acr_pkg::CMD_WRITE) begin
          cfg <= {wr_sreg[6:0], edges.sin};
        end
      end
    end else begin
      wr_cnt <= 5'h00;
    end
  end

  // driven low at end of busy conversion
  assign rd_drive = (state == acr_pkg::ACR_READ) && !rd_end &&
                    (mode_chain || (!fast_en && !edges.sin));

  // Output line drive selection.
  always_comb begin
    next_oe_n = 1'b1;
    next_out  = 1'b0;
    if (start || state == acr_pkg::ACR_CONV) begin
      next_oe_n = 1'b1;
    end else if (rd_drive) begin
      next_oe_n = 1'b0;
      // MSB first, busy low before first fall
      if (mode_chain) begin
        next_out = shreg[acr_pkg::SHIFT_W-1];
      end else begin
        next_out = (fall_cnt == 5'h00) ? 1'b0 : shreg[acr_pkg::SHIFT_W-1];
      end
    end else if (low_force) begin
      next_oe_n = 1'b0;
      next_out  = (state == acr_pkg::ACR_WRITE) ? wr_sreg[15] : 1'b0;
    end
  end

  // Registered output pins.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_out_line <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_line <= next_out;
      serial_out_oe_n <= next_oe_n;
    end
  end

  // a_start_release: output released after start.
  a_start_release: assert property (@(posedge ref_clk) disable iff (rst)
    start |=> serial_out_oe_n)
    else $error("Output not released after conversion start.");

  // a_both_low: low when both inputs low in idle.
  a_both_low: assert property (@(posedge ref_clk) disable iff (rst)
    (low_force && state == acr_pkg::ACR_IDLE && !start) |=> !serial_out_oe_n)
    else $error("Output not driven when both lines low.");

  // a_busy_flag: busy indicator drives low after done.
  a_busy_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (conv_done && !mode_chain && !fast_en && !edges.sin) |=> ##1 (!serial_out_oe_n || start))
    else $error("Busy indicator not driven at conversion end.");

  // a_acq_idle: acquisition follows completion.
  a_acq_idle: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done |=> acquiring)
    else $error("Acquisition not entered after conversion.");

  // a_release_end: released on 17th fall.
  a_release_end: assert property (@(posedge ref_clk) disable iff (rst)
    rd_end && !start |=> serial_out_oe_n)
    else $error("Output not released at end of busy readback.");

  // a_chain_mode: chain mode taken at start.
  a_chain_mode: assert property (@(posedge ref_clk) disable iff (rst)
    start && !edges.sclk && !edges.sin |=> mode_chain)
    else $error("Daisy-chain mode not selected.");

  // a_chain_msb: chain shows MSB at completion.
  a_chain_msb: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done && mode_chain |=> ##1 (serial_out_line == $past(conv_result[15], 2) || start))
    else $error("Chain MSB not presented.");

  // a_chain_capture: input bit captured on rising edge.
  a_chain_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (state == acr_pkg::ACR_READ && mode_chain && edges.sclk_rise && !edges.sclk_fall
     && !conv_done) |=> chain_in == $past(edges.sin))
    else $error("Chain input not captured.");

  // a_no_fast_chain: fast readback off in chain mode.
  a_no_fast_chain: assert property (@(posedge ref_clk) disable iff (rst)
    mode_chain |-> !fast_en)
    else $error("Fast readback active in chain mode.");
endmodule

// ### verif/acr_host_model.sv
`timescale 1ns/1ns
// Purpose: Host model driving the trigger, serial clock and serial input lines.
// Assumes: The output line has a pull-up; the serial clock period is 400 ns.
// Notes:   Lines change on ref_clk falling edges; the clock stands low between frames.
module acr_host_model (
  input  wire logic ref_clk,
  input  wire logic serial_out_line,
  input  wire logic serial_out_oe_n,
  output logic      conversion_trigger,
  output logic      serial_in_line,
  output logic      serial_clk,
  output logic      wire_level
);
  // A released output floats to the pull-up level, so a fall is the interrupt.
  assign wire_level = serial_out_oe_n ? 1'b1 : serial_out_line;

  // All lines start low.
  initial begin
    conversion_trigger = 1'b0;
    serial_in_line     = 1'b0;
    serial_clk         = 1'b0;
  end

  // Waits a number of falling reference clock edges.
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // clock only in frames.
  // Runs n serial clocks; tx leaves MSB first, rx holds the level seen before
  // each rise and skew marks a bit that changed before the following fall.
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx,
                      output logic [31:0] skew);
    logic a;
    rx   = '0;
    skew = '0;
    for (int i = 0; i < n; i++) begin
      serial_in_line = tx[n-1-i];
      idle(4);
      a          = wire_level;
      serial_clk = 1'b1;
      idle(4);
      rx[n-1-i]   = a;
      skew[n-1-i] = a ^ wire_level;
      serial_clk  = 1'b0;
    end
    idle(4);
  endtask
endmodule

// ### verif/tb_adc_busy_and_chain_readout.sv
`timescale 1ns/1ns
// Purpose: Self-checking bench for the converter serial readout block.
// Assumes: The host model drives the link; changes land on ref_clk falling edges.
// Notes:   Result words are not predictable, so framing, levels and passes are checked.
module tb_adc_busy_and_chain_readout;
  typedef struct packed {
    logic sin;
    logic sclk;
    logic chain;
    logic oe_n;
  } acr_row_t;
  // Start levels of serial input and clock, expected mode and output enable.
  localparam acr_row_t ROWS [0:2] = '{4'h9, 4'h2, 4'hd};

  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        serial_out_line;
  logic        serial_out_oe_n;
  logic        chain_mode;
  logic        acquiring;
  logic        conversion_trigger;
  logic        serial_in_line;
  logic        serial_clk;
  logic        wire_level;
  logic [31:0] rx;
  logic [31:0] skew;
  int          n_fail  = 0;
  int          n_tests = 0;

  // Reference clock with a 50 ns period.
  always #25 ref_clk = ~ref_clk;

  acr_top dut (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .conversion_trigger(conversion_trigger),
    .serial_in_line    (serial_in_line),
    .serial_clk        (serial_clk),
    .serial_out_line   (serial_out_line),
    .serial_out_oe_n   (serial_out_oe_n),
    .chain_mode        (chain_mode),
    .acquiring         (acquiring)
  );

  acr_host_model host (
    .ref_clk           (ref_clk),
    .serial_out_line   (serial_out_line),
    .serial_out_oe_n   (serial_out_oe_n),
    .conversion_trigger(conversion_trigger),
    .serial_in_line    (serial_in_line),
    .serial_clk        (serial_clk),
    .wire_level        (wire_level)
  );

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic test_done;
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Sets the start levels, then raises the trigger.
  // trigger held high.
  task automatic start(input logic s, input logic k);
    host.serial_in_line = s;
    host.serial_clk     = k;
    host.idle(2);
    host.conversion_trigger = 1'b1;
  endtask

  // Ends a frame with every line low.
  task automatic stop;
    host.conversion_trigger = 1'b0;
    host.serial_clk         = 1'b0;
    host.serial_in_line     = 1'b0;
    host.idle(10);
  endtask

  // Starts a busy-mode conversion and pulls the serial input low early, as the host must.
  task automatic start_busy;
    start(1'b1, 1'b0);
    host.idle(3);
    host.serial_in_line = 1'b0;
  endtask

  // Waits a bounded time for the line to be pulled low.
  task automatic wait_irq;
    int k;
    k = 0;
    while (wire_level !== 1'b0 && k < 40) begin
      host.idle(1);
      k++;
    end
    chk("busy interrupt", 32'h0, {31'h0, wire_level});
  endtask

  // Checks the levels that reset leaves.
  task automatic chk_reset;
    chk("oe_n in reset", 32'h1, {31'h0, serial_out_oe_n});
    chk("chain_mode in reset", 32'h0, {31'h0, chain_mode});
    chk("acquiring in reset", 32'h1, {31'h0, acquiring});
  endtask

  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    repeat (19) @(negedge ref_clk);
    chk_reset;
    host.idle(1);
    rst = 1'b0;
    host.idle(5);
    chk("idle drive", 32'h0, {31'h0, wire_level, serial_out_oe_n});
    foreach (ROWS[r]) begin
      start(ROWS[r].sin, ROWS[r].sclk);
      host.idle(5);
      chk("acquiring in conversion", 32'h0, {31'h0, acquiring});
      if (ROWS[r].sin) begin
        chk("released at start", 32'h1, {31'h0, serial_out_oe_n});
      end
      host.idle(15);
      chk("mode", {31'h0, ROWS[r].chain}, {31'h0, chain_mode});
      chk("acquiring after", 32'h1, {31'h0, acquiring});
      chk("enable after", {31'h0, ROWS[r].oe_n}, {31'h0, serial_out_oe_n});
      stop;
    end
    start_busy;
    wait_irq;
    host.xfer(17, 32'h0, rx, skew);
    chk("busy bits stable", 32'h0, skew);
    chk("released at last fall", 32'h1, {31'h0, serial_out_oe_n});
    stop;
    start_busy;
    wait_irq;
    host.xfer(5, 32'h0, rx, skew);
    host.serial_in_line = 1'b1;
    host.idle(5);
    chk("released by deselect", 32'h1, {31'h0, serial_out_oe_n});
    stop;
    start(1'b0, 1'b0);
    host.idle(20);
    host.xfer(24, 32'h00a50000, rx, skew);
    chk("chain pass", 32'ha5, {24'h0, rx[7:0]});
    chk("chain bits stable", 32'h0, skew);
    stop;
    host.xfer(16, {16'h0, 8'h14, 8'h13}, rx, skew);
    stop;
    start(1'b0, 1'b0);
    host.idle(20);
    host.xfer(30, 32'h29400000, rx, skew);
    chk("status bits", 32'h3, {26'h0, rx[13:8]});
    chk("chain pass with status", 32'ha5, {24'h0, rx[7:0]});
    stop;
    start_busy;
    host.idle(30);
    chk("fast mode no busy", 32'h1, {31'h0, serial_out_oe_n});
    stop;
    start(1'b1, 1'b0);
    host.idle(4);
    rst = 1'b1;
    stop;
    host.idle(10);
    chk_reset;
    rst = 1'b0;
    host.idle(5);
    chk("idle drive after reset", 32'h0, {31'h0, wire_level, serial_out_oe_n});
    test_done;
  end

  // Cuts a hang short long after the tests should have ended.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done;
  end
endmodule
